// ===== src/aphp_regs.svh
// Timing constants and mode codes for the asynchronous parallel host port.
`ifndef APHP_REGS_SVH
`define APHP_REGS_SVH
`define APHP_CLK_PERIOD_NS    50
`define APHP_STYLE_CS_TIMED   3'h4
`define APHP_STYLE_STROBE     3'h3
`define APHP_CS_RR_MAX_NS     49
`define APHP_CS_WR_MAX_NS     182
`define APHP_ST_RR_MAX_NS     45
`define APHP_ST_WR_MAX_NS     182
`define APHP_DATA_RR_MAX_NS   40
`define APHP_DATA_WR_MAX_NS   192
`define APHP_WAIT_CYC(ns)     (((ns) / `APHP_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `APHP_CLK_PERIOD_NS))
`endif

// ===== src/aphp_pkg.sv
// Types shared by the asynchronous parallel host port.
package aphp_pkg;
    typedef enum logic [2:0] {
        APHP_OFF      = 3'h0,
        APHP_CS_TIMED = 3'h1,
        APHP_STROBE   = 3'h2
    } aphp_style_t;

    typedef enum logic [3:0] {
        APHP_IDLE = 4'h1,
        APHP_WAIT = 4'h2,
        APHP_DONE = 4'h4,
        APHP_HOLD = 4'h8
    } aphp_state_t;
endpackage

// ===== src/aphp_host_port.sv
// Asynchronous parallel host port: chip-select-timed and strobe styles.
`timescale 1ns/10ps
`include "aphp_regs.svh"

module aphp_host_port
    import aphp_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic [2:0]    host_port_style_pins,
    input  wire logic          chip_select_n,
    input  wire logic          write_strobe_n,
    input  wire logic          read_strobe_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] data_in,
    output logic [DW-1:0]      data_out,
    output logic               data_oe_n,
    output logic               transfer_acknowledge,
    output logic               transfer_acknowledge_oe_n,
    output logic [AW-1:0]      core_addr,
    output logic [DW-1:0]      core_wdata,
    output logic               core_wr,
    output logic               core_rd,
    input  wire logic [DW-1:0] core_rdata
);
    // One clock is the shortest answer this clock can give, so a read after read holds its
    // acknowledge for one full period; a faster clock would be needed to come under that bound.
    localparam logic [2:0] CYC_CS_RR = 3'(`APHP_WAIT_CYC(`APHP_CS_RR_MAX_NS));
    localparam logic [2:0] CYC_CS_WR = 3'(`APHP_WAIT_CYC(`APHP_CS_WR_MAX_NS));
    localparam logic [2:0] CYC_ST_RR = 3'(`APHP_WAIT_CYC(`APHP_ST_RR_MAX_NS));
    localparam logic [2:0] CYC_ST_WR = 3'(`APHP_WAIT_CYC(`APHP_ST_WR_MAX_NS));

    logic [2:0]    pins_s1, pins_s2;
    logic          cs_s1, cs_s2, wr_s1, wr_s2, rd_s1, rd_s2;
    logic [AW-1:0] a_s1, a_s2;
    logic [DW-1:0] d_s1, d_s2;
    logic          style_taken;
    aphp_style_t   style;
    aphp_state_t   state;
    logic [2:0]    wait_cnt;
    logic          last_write;
    logic          is_write;
    logic          cs_act, st_act, start;

    // Pins come from the host's timing domain; two flops before use.
    always_ff @(posedge clk_sys) begin
        pins_s1 <= host_port_style_pins;
        pins_s2 <= pins_s1;
        cs_s1   <= chip_select_n;
        cs_s2   <= cs_s1;
        wr_s1   <= write_strobe_n;
        wr_s2   <= wr_s1;
        rd_s1   <= read_strobe_n;
        rd_s2   <= rd_s1;
        a_s1    <= addr;
        a_s2    <= a_s1;
        d_s1    <= data_in;
        d_s2    <= d_s1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            style_taken <= 1'b0;
            style       <= APHP_OFF;
        end else if (!style_taken) begin
            style_taken <= 1'b1;
            case (pins_s2)
                `APHP_STYLE_CS_TIMED: style <= APHP_CS_TIMED;
                `APHP_STYLE_STROBE:   style <= APHP_STROBE;
                default:              style <= APHP_OFF;
            endcase
        end
    end

    // framed by chip select; strobes qualified by chip select.
    assign cs_act = (style == APHP_CS_TIMED) && !cs_s2;
    assign st_act = (style == APHP_STROBE) && !cs_s2 && (!rd_s2 || !wr_s2);
    // direction relies on the host holding the strobe level.
    assign is_write = (style == APHP_CS_TIMED) ? !wr_s2 : !wr_s2;
    assign start = (state == APHP_IDLE) && (cs_act || st_act);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state    <= APHP_IDLE;
            wait_cnt <= 3'h0;
        end else begin
            case (state)
                APHP_IDLE: begin
                    if (start) begin
                        state <= APHP_WAIT;
                        if (style == APHP_CS_TIMED)
                            wait_cnt <= last_write ? CYC_CS_WR : CYC_CS_RR;
                        else
                            wait_cnt <= last_write ? CYC_ST_WR : CYC_ST_RR;
                    end
                end
                APHP_WAIT: begin
                    if (wait_cnt <= 3'h1)
                        state <= APHP_DONE;
                    else
                        wait_cnt <= wait_cnt - 3'h1;
                end
                APHP_DONE: state <= APHP_HOLD;
                APHP_HOLD: begin
                    if (!(cs_act || st_act))
                        state <= APHP_IDLE;
                end
                default: state <= APHP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            last_write <= 1'b0;
        else if (start)
            last_write <= is_write;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_addr  <= '0;
            core_wdata <= '0;
            core_wr    <= 1'b0;
            core_rd    <= 1'b0;
        end else begin
            core_wr <= start && is_write;
            core_rd <= start && !is_write;
            if (start) begin
                core_addr  <= a_s2;
                core_wdata <= d_s2;
            end
        end
    end

    // core_rdata latched on every wait cycle, reads and writes alike, up to the edge where ready signals completion
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            data_out <= '0;
        else if (state == APHP_WAIT && !last_write)
            data_out <= core_rdata;
        else if (state == APHP_WAIT)
            data_out <= core_rdata;
    end

    // ready low while waiting in strobe mode; high while waiting in chip-select mode.
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            transfer_acknowledge <= 1'b0;
        else if (style == APHP_CS_TIMED)
            transfer_acknowledge <= start || (state == APHP_WAIT && wait_cnt > 3'h1);
        else
            transfer_acknowledge <= !(start || (state == APHP_WAIT && wait_cnt > 3'h1));
    end

    // drive only during a chip-selected access
    assign transfer_acknowledge_oe_n = !((cs_act || st_act) && state != APHP_IDLE);
    assign data_oe_n = !((cs_act || st_act) && state != APHP_IDLE && !last_write);

    // host spacing is assumed; the device only times its own answer.

    property p_ack_len;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(state == APHP_WAIT) |-> ##[1:5] (state == APHP_DONE);
    endproperty
    a_ack_bounded: assert property (p_ack_len) else $error("ack wait too long");

    a_ready_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (style == APHP_STROBE && start) |=> !transfer_acknowledge) else $error("ready not low");
    a_ack_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (style == APHP_CS_TIMED && start) |=> transfer_acknowledge) else $error("ack not high");

    a_drive_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_s2 |-> transfer_acknowledge_oe_n && data_oe_n) else $error("driving while idle");

    sequence s_cs_start;
        (style == APHP_CS_TIMED) && start;
    endsequence

    sequence s_st_start;
        (style == APHP_STROBE) && start;
    endsequence

    sequence s_ack_pulse;
        transfer_acknowledge ##[1:3] !transfer_acknowledge;
    endsequence

    sequence s_ready_pulse;
        !transfer_acknowledge ##[1:3] transfer_acknowledge;
    endsequence

    property p_ack_falls;
        @(posedge clk_sys) disable iff (!rst_n)
        s_cs_start |=> s_ack_pulse;
    endproperty

    property p_ready_rises;
        @(posedge clk_sys) disable iff (!rst_n)
        s_st_start |=> s_ready_pulse;
    endproperty

    a_ack_falls: assert property (p_ack_falls) else $error("ack did not fall after wait");
    a_ready_rises: assert property (p_ready_rises) else $error("ready did not rise after wait");

    a_ack_rr_short: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (style == APHP_CS_TIMED && start && !last_write) |=> transfer_acknowledge ##1 !transfer_acknowledge)
        else $error("read after read ack too long");

    a_core_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (core_wr || core_rd) |=> !(core_wr || core_rd))
        else $error("core strobe longer than one cycle");

    a_off_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (style == APHP_OFF) |-> (state == APHP_IDLE) && transfer_acknowledge_oe_n)
        else $error("port active while off");
endmodule

// ===== tb/aphp_host_model.sv
// Behavioural host processor driving the parallel port.
`timescale 1ns/10ps
module aphp_host_model (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       wr,
    input  wire logic       strobe_mode,
    input  wire logic [7:0] a,
    input  wire logic [7:0] d,
    input  wire logic       ack,
    input  wire logic       ack_oe_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output logic            chip_select_n,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic [7:0]      addr,
    output logic [7:0]      data_in,
    output logic            busy,
    output logic [7:0]      rdata,
    output int              hi
);
    int n;
    initial begin
        {chip_select_n, write_strobe_n, read_strobe_n, busy} = 4'hE;
        addr = 8'h00;
        data_in = 8'hFF;
        rdata = 8'h00;
        hi = 0;
        forever begin
            @(posedge clk_sys);
            if (go === 1'b1 && !busy) begin
                busy <= 1'b1;
                addr <= a;
                data_in <= wr ? d : ~d;
                write_strobe_n <= !(wr && !strobe_mode);
                @(posedge clk_sys);
                chip_select_n <= 1'b0;
                if (strobe_mode) {write_strobe_n, read_strobe_n} <= {!wr, wr};
                n = 0;
                hi = 0;
                while (n < 12) begin
                    @(posedge clk_sys);
                    n++;
                    if (ack_oe_n === 1'b0 && ack !== strobe_mode) hi++;
                    else if (hi > 0) break;
                end
                // An undriven data bus floats to its pull-up level.
                rdata <= (data_oe_n === 1'b0) ? data_out : 8'hFF;
                {chip_select_n, write_strobe_n, read_strobe_n} <= 3'h7;
                data_in <= ~data_in;
                repeat (4) @(posedge clk_sys);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== tb/aphp_host_port_tb.sv
// Self-checking bench for the asynchronous parallel host port.
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module aphp_host_port_tb;
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d; int hi;} aphp_row_t;
    logic       clk_sys = 1'b0, rst_n = 1'b0, go = 1'b0, wr = 1'b0, sm = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [7:0] a = 8'h00, d = 8'h00, core_rdata = 8'h00, cw_a = 8'h00, cw_d = 8'h00, cr_a = 8'h00;
    logic       cs_n, wr_n, rd_n, busy, ack, ack_oe_n, d_oe_n, core_wr, core_rd;
    logic [7:0] addr, data_in, data_out, core_addr, core_wdata, rdata;
    int         hi, failures = 0, num_checks = 0, cyc = 0;
    // First access after reset has no history, so its length is not judged.
    aphp_row_t  rows [5] = '{'{1'b1, 8'h5A, 8'hC3, 0}, '{1'b0, 8'h5A, 8'h3C, 3}, '{1'b0, 8'hA5, 8'h96, 1},
                            '{1'b1, 8'h0F, 8'h81, 1}, '{1'b1, 8'hF0, 8'h7E, 3}};
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (core_wr === 1'b1) {cw_a, cw_d} <= {core_addr, core_wdata};
        if (core_rd === 1'b1) cr_a <= core_addr;
        if (cyc == 3000) begin
            failures++;
            give_verdict();
        end
    end
    aphp_host_port DUT (.clk_sys, .rst_n, .host_port_style_pins(pins), .chip_select_n(cs_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .addr, .data_in, .data_out, .data_oe_n(d_oe_n),
        .transfer_acknowledge(ack), .transfer_acknowledge_oe_n(ack_oe_n), .core_addr, .core_wdata,
        .core_wr, .core_rd, .core_rdata);
    aphp_host_model HOST (.clk_sys, .go, .wr, .strobe_mode(sm), .a, .d, .ack, .ack_oe_n, .data_out, .data_oe_n(d_oe_n),
        .chip_select_n(cs_n), .write_strobe_n(wr_n), .read_strobe_n(rd_n), .addr, .data_in, .busy, .rdata, .hi);
    task automatic restart(input logic [2:0] p);
        rst_n <= 1'b0;
        pins <= p;
        repeat (3) @(posedge clk_sys);
        `CHK("rst_oe", 2'h3, {d_oe_n, ack_oe_n})
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask
    task automatic access(input aphp_row_t r);
        wr <= r.wr;
        a <= r.a;
        d <= r.d;
        core_rdata <= r.d;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (busy) @(posedge clk_sys);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        for (int s = 0; s < 2; s++) begin
            restart(s ? 3'h3 : 3'h4);
            sm <= s[0];
            foreach (rows[i]) begin
                access(rows[i]);
                if (rows[i].hi > 0) `CHK("ack_len", rows[i].hi, hi)
                if (!rows[i].wr) `CHK("rdata", rows[i].d, rdata)
                if (rows[i].wr) `CHK("core_w", {rows[i].a, rows[i].d}, {cw_a, cw_d})
                if (!rows[i].wr) `CHK("core_r", rows[i].a, cr_a)
                `CHK("oe_n", 2'h3, {d_oe_n, ack_oe_n})
            end
        end
        restart(3'h0);
        access(rows[1]);
        `CHK("off_ack", 0, hi)
        give_verdict();
    end
endmodule
